// ==== logic/sec_consts.svh ====
`ifndef SEC_CONSTS_SVH
`define SEC_CONSTS_SVH

// ==========================================================
// Opcodes
`define SEC_OP_SET_WL   8'h06
`define SEC_OP_CLR_WL   8'h04
`define SEC_OP_READ     8'h03
`define SEC_OP_WRITE    8'h02

// ==========================================================
// Geometry
`define SEC_DEPTH       256
`define SEC_PAGE_BYTES  4
`define SEC_MAX_DBYTES  3'h4
`define SEC_OVER_DBYTES 3'h5
`define SEC_ADDR_LAST   8'hFF

// ==========================================================
// Timing
`define SEC_CLK_MHZ     50
`define SEC_PROG_US     5000

`endif

// ==== logic/sec_pkg.sv ====
package sec_pkg;

   // ==========================================================
   // Pin group
   typedef struct packed {
      logic sck;
      logic cs_n;
      logic si;
      logic hold_n;
      logic wp_n;
   } sec_pins_t;

   // ==========================================================
   // Transaction states, Gray along idle-opcode-address-write data; address to read data changes two bits
   typedef enum logic [2:0] {
      SEC_IDLE = 3'h0,
      SEC_OPC  = 3'h1,
      SEC_ADR  = 3'h3,
      SEC_DIN  = 3'h2,
      SEC_DOUT = 3'h6,
      SEC_CMDW = 3'h7,
      SEC_SKIP = 3'h5
   } sec_state_t;

endpackage : sec_pkg

// ==== logic/sec_eeprom.sv ====
// Notes on behaviour
// - Input bits taken on serial clock rise; output changes only after falls.
// - First bit is the first rising edge after chip select falls.
// - Output enable is off while chip select is high.
// - No operation until a high-to-low chip select transition is seen.
// - Write-protect low blocks writes and the set-latch command; reads and clear-latch still work.
// - Write-protect falling during selection abandons the write; program cycle unaffected.
// - Pause low ignores clock and data without resetting the transaction.
// - After pause release the transaction resumes from the same bit.
// - Eight-bit instruction register; everything sent most significant bit first.
// - Opcode 06h sets the write latch, 04h clears it.
// - Opcode 03h reads, 02h writes one to four bytes.
// - Write needs latch set; latch cleared at reset, after program, on protect.
// - Read streams bytes after opcode and address until chip select rises.
// - Read address increments per byte and wraps from FFh to 00h.
// - Set-latch opcode must end the selection, else it is ignored.
// - Write is opcode, address, one to four data bytes within a page.
// - Write address wraps inside its four-byte page, overwriting loaded data.
// - Write commits only if deselected right after clock 24, 32, 40 or 48.
`timescale 1ns/1ps
`include "sec_consts.svh"

module sec_eeprom #(
   parameter int unsigned PROG_CYCLES = `SEC_PROG_US * `SEC_CLK_MHZ
) (
   input  wire logic              clk,
   input  wire logic              rstn,
   input  wire sec_pkg::sec_pins_t pins,
   output logic                   so_o,
   output logic                   so_oe,
   output logic                   prog_busy
);

   localparam int CW = $clog2(PROG_CYCLES + 1);

   // ==========================================================
   // State
   sec_pkg::sec_state_t state_ff;
   logic                sck_q_ff;
   logic                cs_q_ff;
   logic [2:0]          bit_cnt_ff;
   logic [7:0]          sr_ff;
   logic [7:0]          op_ff;
   logic [7:0]          addr_ff;
   logic [2:0]          ocnt_ff;
   logic [6:0]          osr_ff;
   logic [2:0]          nbytes_ff;
   logic [3:0]          vmask_ff;
   logic                abort_ff;
   logic                wel_ff;
   logic                busy_ff;
   logic [CW-1:0]       pcnt_ff;
   logic                so_ff;
   logic                oe_ff;
   logic [7:0]          mem   [`SEC_DEPTH];
   logic [7:0]          pgbuf [`SEC_PAGE_BYTES];

   logic       cs_fall;
   logic       cs_rise;
   logic       live;
   logic       rise;
   logic       fall;
   logic [7:0] nxt_byte;
   logic       byte_done;
   logic       commit_go;
   logic       prog_done;

   assign cs_fall   = cs_q_ff & ~pins.cs_n;
   assign cs_rise   = ~cs_q_ff & pins.cs_n;
   // Pause gates both edges, so counters simply freeze in place.
   assign live      = ~pins.cs_n & pins.hold_n & ~busy_ff;
   assign rise      = live & pins.sck & ~sck_q_ff;
   assign fall      = live & ~pins.sck & sck_q_ff;
   assign nxt_byte  = {sr_ff[6:0], pins.si};
   assign byte_done = rise & (bit_cnt_ff == 3'h7);
   assign commit_go = cs_rise & (state_ff == sec_pkg::SEC_DIN) & (bit_cnt_ff == 3'h0)
                    & (nbytes_ff != 3'h0) & (nbytes_ff <= `SEC_MAX_DBYTES)
                    & wel_ff & pins.wp_n & ~abort_ff;
   assign prog_done = busy_ff & (pcnt_ff == '0);

   assign so_o      = so_ff;
   assign so_oe     = oe_ff;
   assign prog_busy = busy_ff;

   // ==========================================================
   // Pin history
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sck_q_ff <= 1'b0;
         cs_q_ff  <= 1'b0;
      end
      else
      begin
         sck_q_ff <= pins.sck;
         cs_q_ff  <= pins.cs_n;
      end
   end

   // ==========================================================
   // Input shifter and bit position
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         bit_cnt_ff <= 3'h0;
         sr_ff      <= 8'h00;
      end
      else if (pins.cs_n || cs_fall)
         bit_cnt_ff <= 3'h0;
      else if (rise)
      begin
         bit_cnt_ff <= bit_cnt_ff + 3'h1;
         sr_ff      <= nxt_byte;
      end
   end

   // ==========================================================
   // Transaction sequencer
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_ff <= sec_pkg::SEC_IDLE;
         op_ff    <= 8'h00;
      end
      else if (pins.cs_n)
         state_ff <= sec_pkg::SEC_IDLE;
      else if (cs_fall)
         // Only a falling select leaves idle, so nothing runs before one.
         state_ff <= busy_ff ? sec_pkg::SEC_SKIP : sec_pkg::SEC_OPC;
      else if (byte_done)
      begin
         unique case (state_ff)
            sec_pkg::SEC_OPC:
            begin
               op_ff <= nxt_byte;
               unique case (nxt_byte)
                  `SEC_OP_SET_WL, `SEC_OP_CLR_WL: state_ff <= sec_pkg::SEC_CMDW;
                  `SEC_OP_READ, `SEC_OP_WRITE:    state_ff <= sec_pkg::SEC_ADR;
                  default:                        state_ff <= sec_pkg::SEC_SKIP;
               endcase
            end
            sec_pkg::SEC_ADR:
               state_ff <= (op_ff == `SEC_OP_READ) ? sec_pkg::SEC_DOUT : sec_pkg::SEC_DIN;
            sec_pkg::SEC_CMDW:
               state_ff <= sec_pkg::SEC_SKIP;
            sec_pkg::SEC_IDLE, sec_pkg::SEC_DIN, sec_pkg::SEC_DOUT, sec_pkg::SEC_SKIP:
               state_ff <= state_ff;
         endcase
      end
   end

   // ==========================================================
   // Address counter, page buffer and write bookkeeping
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         addr_ff   <= 8'h00;
         nbytes_ff <= 3'h0;
         vmask_ff  <= 4'h0;
      end
      // A selection refused during programming must not wipe the page being written.
      else if (cs_fall && !busy_ff)
      begin
         nbytes_ff <= 3'h0;
         vmask_ff  <= 4'h0;
      end
      else if (byte_done && state_ff == sec_pkg::SEC_ADR)
         addr_ff <= nxt_byte;
      else if (byte_done && state_ff == sec_pkg::SEC_DIN)
      begin
         vmask_ff[addr_ff[1:0]] <= 1'b1;
         addr_ff <= {addr_ff[7:2], addr_ff[1:0] + 2'h1};
         if (nbytes_ff != `SEC_OVER_DBYTES)
            nbytes_ff <= nbytes_ff + 3'h1;
      end
      else if (fall && state_ff == sec_pkg::SEC_DOUT && ocnt_ff == 3'h0)
         addr_ff <= addr_ff + 8'h01;
   end

   always_ff @(posedge clk)
   begin
      if (byte_done && state_ff == sec_pkg::SEC_DIN)
         pgbuf[addr_ff[1:0]] <= nxt_byte;
   end

   // Protect falling at any point of the selection spoils the write.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         abort_ff <= 1'b0;
      else if (!pins.cs_n && !pins.wp_n)
         abort_ff <= 1'b1;
      else if (cs_fall)
         abort_ff <= 1'b0;
   end

   // ==========================================================
   // Write latch
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         wel_ff <= 1'b0;
      else if (!pins.wp_n || prog_done)
         wel_ff <= 1'b0;
      else if (cs_rise && state_ff == sec_pkg::SEC_CMDW && bit_cnt_ff == 3'h0)
         wel_ff <= (op_ff == `SEC_OP_SET_WL);
   end

   // ==========================================================
   // Self-timed program cycle
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         busy_ff <= 1'b0;
         pcnt_ff <= '0;
      end
      else if (commit_go)
      begin
         busy_ff <= 1'b1;
         pcnt_ff <= CW'(PROG_CYCLES - 1);
      end
      else if (prog_done)
         busy_ff <= 1'b0;
      else if (busy_ff)
         pcnt_ff <= pcnt_ff - 1'b1;
   end

   // Array is written at the end of the cycle; protect no longer matters then.
   always_ff @(posedge clk)
   begin
      if (prog_done)
         for (int i = 0; i < `SEC_PAGE_BYTES; i++)
            if (vmask_ff[i])
               mem[{addr_ff[7:2], 2'(i)}] <= pgbuf[i];
   end

   // ==========================================================
   // Serial output
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         so_ff   <= 1'b0;
         osr_ff  <= 7'h00;
         ocnt_ff <= 3'h0;
      end
      else if (cs_fall)
         ocnt_ff <= 3'h0;
      else if (fall && state_ff == sec_pkg::SEC_DOUT)
      begin
         ocnt_ff <= ocnt_ff + 3'h1;
         if (ocnt_ff == 3'h0)
         begin
            so_ff  <= mem[addr_ff][7];
            osr_ff <= mem[addr_ff][6:0];
         end
         else
         begin
            so_ff  <= osr_ff[6];
            osr_ff <= {osr_ff[5:0], 1'b0};
         end
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         oe_ff <= 1'b0;
      else
         oe_ff <= ~pins.cs_n;
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   so_hiz_a: assert property (pins.cs_n |=> !so_oe)
      else $error("output driven while deselected");
   so_edge_a: assert property ($changed(so_o) |-> $past(fall))
      else $error("output changed without falling clock");
   arm_only_a: assert property ((state_ff == sec_pkg::SEC_IDLE) && !cs_fall |=>
      state_ff == sec_pkg::SEC_IDLE) else $error("left idle without select fall");
   pause_freeze_a: assert property (!pins.hold_n && !pins.cs_n && !cs_fall |=>
      $stable(bit_cnt_ff) && $stable(sr_ff)) else $error("paused transfer moved");
   wel_clear_a: assert property (!pins.wp_n |=> !wel_ff)
      else $error("latch survived protect low");
   wel_set_a: assert property (cs_rise && state_ff == sec_pkg::SEC_CMDW && bit_cnt_ff == 3'h0
      && op_ff == `SEC_OP_SET_WL && pins.wp_n |=> wel_ff)
      else $error("set-latch command lost");
   commit_gate_a: assert property ($rose(busy_ff) |-> $past(wel_ff) && $past(pins.wp_n)
      && !$past(abort_ff)) else $error("program started without permission");
   commit_cnt_a: assert property ($rose(busy_ff) |-> $past(bit_cnt_ff) == 3'h0
      && $past(nbytes_ff) inside {[3'h1:3'h4]}) else $error("commit at wrong clock count");
   read_wrap_a: assert property (fall && state_ff == sec_pkg::SEC_DOUT && ocnt_ff == 3'h0
      && addr_ff == `SEC_ADDR_LAST |=> addr_ff == 8'h00) else $error("read address did not wrap");
   op_decode_a: assert property (byte_done && state_ff == sec_pkg::SEC_OPC
      && nxt_byte == `SEC_OP_READ |=> state_ff == sec_pkg::SEC_ADR) else $error("read not decoded");
   prog_wel_a: assert property (prog_done |=> !busy_ff && !wel_ff)
      else $error("program end mishandled");

   read_cov: cover property (fall && state_ff == sec_pkg::SEC_DOUT && ocnt_ff == 3'h7);
   commit_cov: cover property (commit_go && nbytes_ff == 3'h4);
   pause_cov: cover property (!pins.hold_n && state_ff == sec_pkg::SEC_DIN);
   set_write_latch_cmd_cov: cover property ($rose(wel_ff));

endmodule : sec_eeprom

// ==== tb/sec_host.sv ====
`timescale 1ns/1ps

module sec_host (
   input  wire logic          clk,
   input  wire logic          so_o,
   output sec_pkg::sec_pins_t pins
);
   logic [7:0] rx;

   // ==========================================================
   // Idle levels: deselected, clock low, pause and protect released
   task automatic park();
      pins.sck    <= 1'b0;
      pins.cs_n   <= 1'b1;
      pins.si     <= 1'b0;
      pins.hold_n <= 1'b1;
      pins.wp_n   <= 1'b1;
   endtask : park

   // ==========================================================
   // Pin steps, each launched just after a rising clk edge
   task automatic step(input int n);
      repeat (n) @(posedge clk);
   endtask : step

   task automatic sel();
      @(posedge clk);
      pins.cs_n <= 1'b0;
      step(3);
   endtask : sel

   // The clock is parked low before deselect, so it stands still between frames.
   task automatic desel();
      @(posedge clk);
      pins.sck <= 1'b0;
      step(2);
      pins.cs_n <= 1'b1;
      pins.si <= ~pins.si;
      step(3);
   endtask : desel

   task automatic bits(input logic [7:0] v, input int n);
      for (int i = n - 1; i >= 0; i--)
      begin
         @(posedge clk);
         pins.sck <= 1'b0;
         pins.si <= v[i];
         step(2);
         pins.sck <= 1'b1;
         rx = {rx[6:0], so_o};
         step(2);
      end
   endtask : bits

   // The one clock pulse inside the pause carries junk that must not be taken.
   task automatic pause();
      @(posedge clk);
      pins.sck <= 1'b0;
      step(2);
      pins.hold_n <= 1'b0;
      repeat (2)
      begin
         step(2);
         pins.sck <= ~pins.sck;
         pins.si <= ~pins.si;
      end
      step(2);
      pins.hold_n <= 1'b1;
      step(2);
   endtask : pause

   task automatic set_wp(input logic v);
      @(posedge clk);
      pins.wp_n <= v;
      step(2);
   endtask : set_wp
endmodule : sec_host

// ==== tb/spi_eeprom_command_interface_test.sv ====
`timescale 1ns/1ps
`include "sec_consts.svh"

module spi_eeprom_command_interface_test;
   localparam int PROG = 20;
   localparam int LIMIT = 20000;

   logic               clk = 1'b0;
   logic               rstn = 1'b0;
   sec_pkg::sec_pins_t pins;
   logic               so_o;
   logic               so_oe;
   logic               prog_busy;
   int                 mismatches = 0;
   int                 compares = 0;
   int                 cycles = 0;

   always #10 clk = ~clk;

   sec_host u_host (.clk(clk), .so_o(so_o), .pins(pins));

   sec_eeprom #(.PROG_CYCLES(PROG)) u_dut (
      .clk(clk), .rstn(rstn), .pins(pins), .so_o(so_o), .so_oe(so_oe), .prog_busy(prog_busy));

   // ==========================================================
   // Compare and report
   task automatic cmp1(input string what, input logic exp, input logic got);
      compares++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH %s exp %h got %h", what, exp, got);
      end
   endtask : cmp1

   task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH %s exp %h got %h", what, exp, got);
      end
   endtask : cmp8

   task automatic conclude();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : conclude

   // ==========================================================
   // Transfers
   task automatic cmd(input logic [7:0] op);
      u_host.sel();
      u_host.bits(op, 8);
      u_host.desel();
   endtask : cmd

   // Extra sends a stray tail of bits; cut pulses protect low in mid-frame.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input int n, input int extra,
                     input logic cut, input logic exp);
      u_host.sel();
      u_host.bits(`SEC_OP_WRITE, 8);
      u_host.bits(a, 8);
      if (cut)
      begin
         u_host.set_wp(1'b0);
         u_host.set_wp(1'b1);
      end
      for (int k = 0; k < n; k++)
         u_host.bits(d[31 - 8 * k -: 8], 8);
      u_host.bits(8'h3C, extra);
      u_host.desel();
      cmp1("prog_busy", exp, prog_busy);
      for (int k = 0; k < 100 && prog_busy !== 1'b0; k++)
         @(posedge clk);
      cmp1("busy end", 1'b0, prog_busy);
   endtask : wr

   task automatic rd(input logic [7:0] a, input int n, input logic [23:0] exp, input logic hold);
      u_host.sel();
      u_host.bits(`SEC_OP_READ, 8);
      if (hold)
      begin
         u_host.bits(a >> 4, 4);
         u_host.pause();
         u_host.bits(a, 4);
      end
      else
         u_host.bits(a, 8);
      cmp1("so_oe on", 1'b1, so_oe);
      for (int k = 0; k < n; k++)
      begin
         u_host.bits(8'h96, 8);
         cmp8("read byte", exp[23 - 8 * k -: 8], u_host.rx);
      end
      u_host.desel();
      cmp1("so_oe off", 1'b0, so_oe);
   endtask : rd

   // ==========================================================
   // Scenarios
   task automatic s_commit();
      cmd(`SEC_OP_SET_WL);
      wr(8'h02, 32'hA0A1A2A3, 4, 0, 1'b0, 1'b1);
      wr(8'hFF, 32'hC5000000, 1, 0, 1'b0, 1'b0);
      cmd(`SEC_OP_SET_WL);
      wr(8'hFF, 32'hC5000000, 1, 0, 1'b0, 1'b1);
      rd(8'hFF, 3, 24'hC5A2A3, 1'b0);
   endtask : s_commit

   task automatic s_refuse();
      cmd(`SEC_OP_SET_WL);
      cmd(`SEC_OP_CLR_WL);
      wr(8'h02, 32'h5A000000, 1, 0, 1'b0, 1'b0);
      u_host.sel();
      u_host.bits(`SEC_OP_SET_WL, 8);
      u_host.bits(8'h00, 8);
      u_host.desel();
      wr(8'h02, 32'h5A000000, 1, 0, 1'b0, 1'b0);
      cmd(`SEC_OP_SET_WL);
      wr(8'h02, 32'h5A000000, 1, 4, 1'b0, 1'b0);
      cmd(`SEC_OP_SET_WL);
      wr(8'h02, 32'h5A5A5A5A, 4, 8, 1'b0, 1'b0);
      cmd(`SEC_OP_SET_WL);
      wr(8'h02, 32'h5A000000, 0, 0, 1'b0, 1'b0);
      cmd(`SEC_OP_SET_WL);
      wr(8'h02, 32'h5A000000, 1, 0, 1'b1, 1'b0);
      cmd(`SEC_OP_SET_WL);
      u_host.set_wp(1'b0);
      u_host.set_wp(1'b1);
      wr(8'h02, 32'h5A000000, 1, 0, 1'b0, 1'b0);
   endtask : s_refuse

   // A selection made while programming is ignored and must not spoil the page in flight.
   task automatic s_busy();
      cmd(`SEC_OP_SET_WL);
      u_host.sel();
      u_host.bits(`SEC_OP_WRITE, 8);
      u_host.bits(8'h10, 8);
      u_host.bits(8'h6E, 8);
      u_host.desel();
      cmp1("busy after commit", 1'b1, prog_busy);
      u_host.sel();
      u_host.desel();
      cmp1("busy deselected", 1'b1, prog_busy);
      for (int k = 0; k < 100 && prog_busy !== 1'b0; k++)
         @(posedge clk);
      cmp1("busy done", 1'b0, prog_busy);
      rd(8'h10, 1, 24'h6E0000, 1'b0);
   endtask : s_busy

   task automatic s_pause();
      u_host.set_wp(1'b0);
      rd(8'h02, 2, 24'hA0A100, 1'b1);
      u_host.set_wp(1'b1);
   endtask : s_pause

   initial
   begin
      u_host.park();
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      cmp1("so_oe idle", 1'b0, so_oe);
      s_commit();
      s_refuse();
      s_busy();
      s_pause();
      conclude();
   end

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         mismatches++;
         conclude();
      end
   end
endmodule : spi_eeprom_command_interface_test
